// ### pkg/blis_pkg.sv
// package: register map, field layout and reset values of the block-level interrupt status block
package blis_pkg;
  localparam int NUM_CH = 3;
  localparam int SRC_W = 8;
  localparam logic [7:0] ENABLE_IDX = 8'h20;
  localparam logic [7:0] SUMMARY_IDX = 8'h21;
  localparam logic [7:0] SRC_STATUS_IDX0 = 8'h02;
  localparam logic [7:0] SRC_STATUS_IDX1 = 8'h0A;
  localparam logic [7:0] SRC_STATUS_IDX2 = 8'h12;
  localparam logic [7:0] SRC_ENABLE_IDX0 = 8'h01;
  localparam logic [7:0] SRC_ENABLE_IDX1 = 8'h09;
  localparam logic [7:0] SRC_ENABLE_IDX2 = 8'h11;
  localparam logic [7:0] FLAG_SET_IDX0 = 8'h30;
  localparam logic [7:0] FLAG_SET_IDX1 = 8'h31;
  localparam logic [7:0] FLAG_SET_IDX2 = 8'h32;
  localparam logic [1:0] ADDR_LSB = 2'h2;
  localparam int ADDR_W = 10;
  localparam logic [NUM_CH-1:0] ENABLE_RST = 3'h0;
  localparam logic [NUM_CH-1:0] SUMMARY_RST = 3'h0;
  localparam logic [SRC_W-1:0] SRC_RST = 8'h00;
endpackage

// ### sim/blis_top_bench.sv
// self-checking bench for the block-level interrupt status block
`timescale 1ns/1ps
`default_nettype none
module blis_top_bench
  import blis_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err;
  logic [NUM_CH-1:0] chan_irq;
  int mismatches = 0, comparisons = 0;
  // row: op nibble, index, write data, expected read low byte, expected error nibble
  logic [31:0] rows [22] = '{
    32'h02100000, 32'h12007000, 32'h02000070, 32'h101FF000, 32'h10900000, 32'h111FF000,
    32'h13001000, 32'h02100010, 32'h13102000, 32'h02100010, 32'h109FF000,
    32'h02100030, 32'h13204000, 32'h02100070, 32'h121FF001, 32'h02100070,
    32'h00A00020, 32'h02100050, 32'h12006000, 32'h02100040, 32'h00200010,
    32'h03F00001};
  blis_top i_blis_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_irq(chan_irq));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one APB transfer, then one idle cycle before the next setup
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      xfer(rows[i][28], rows[i][27:20], rows[i][19:12]);
      chk("error", {31'h0, rows[i][0]}, {31'h0, err});
      if (!rows[i][28]) chk("read data", {24'h0, rows[i][11:4]}, rd);
      if (!rows[i][28] && rows[i][27:20] == SUMMARY_IDX) chk("irq", {29'h0, rows[i][6:4]}, {29'h0, chan_irq});
      $display("row %0d done", i);
    end
    xfer(1'b1, FLAG_SET_IDX2, 8'h04);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, SUMMARY_IDX, 8'h00);
    chk("summary after reset", 32'h0, rd);
    xfer(1'b0, ENABLE_IDX, 8'h00);
    chk("enable after reset", 32'h0, rd);
    $display("mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire

// ### verilog/blis_top.sv
// block-level interrupt status register of a three-channel line interface, reached over APB
// Function
// [RULE1] summary register 0x21, read-only, upper bits zero
// [RULE2] bit 2 shows channel 2 pending
// [RULE3] bit 1 shows channel 1 pending
// [RULE4] bit 0 shows channel 0 pending
// [RULE5] set bit holds until source status read
// [RULE6] host reads 0x12, 0x0A, 0x02 for cause
// [RULE7] block enable low blocks channel interrupts
// [RULE8] summary is OR of enabled flags, gated
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module blis_top
  import blis_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] chan_irq
);
  ////////////////////////////////////////////////////////////////
  logic [NUM_CH-1:0] blk_en;
  logic [SRC_W-1:0] src_en [NUM_CH];
  logic [SRC_W-1:0] src_flag [NUM_CH];
  logic [NUM_CH-1:0] summary;
  wire logic [7:0] idx = paddr[ADDR_W-1:ADDR_LSB];
  wire logic setup = psel && !penable;
  wire logic acc = psel && penable && pready;
  wire logic wr_acc = acc && pwrite;
  wire logic rd_acc = acc && !pwrite;
  localparam logic [7:0] st_idx [NUM_CH] = '{SRC_STATUS_IDX0, SRC_STATUS_IDX1, SRC_STATUS_IDX2};
  localparam logic [7:0] en_idx [NUM_CH] = '{SRC_ENABLE_IDX0, SRC_ENABLE_IDX1, SRC_ENABLE_IDX2};
  localparam logic [7:0] fs_idx [NUM_CH] = '{FLAG_SET_IDX0, FLAG_SET_IDX1, FLAG_SET_IDX2};
  logic [NUM_CH-1:0] hit_st, hit_en, hit_fs, next_summary;
  logic [SRC_W-1:0] next_flag [NUM_CH];
  ////////////////////////////////////////////////////////////////
  // per-channel source flags, enables and summary
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      assign hit_st[c] = (idx == st_idx[c]);
      assign hit_en[c] = (idx == en_idx[c]);
      assign hit_fs[c] = (idx == fs_idx[c]);
      // reading source status clears it; new events in the same cycle win
      assign next_flag[c] = ((rd_acc && hit_st[c]) ? SRC_RST : src_flag[c])
                            | ((wr_acc && hit_fs[c]) ? pwdata[SRC_W-1:0] : SRC_RST); // [RULE5]
      // enabled flags ORed, gated by block enable
      assign next_summary[c] = blk_en[c] && |(next_flag[c] & src_en[c]); // [RULE2] [RULE3] [RULE4] [RULE7] [RULE8]
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          src_flag[c] <= SRC_RST;
          src_en[c] <= SRC_RST;
        end else begin
          src_flag[c] <= next_flag[c];
          if (wr_acc && hit_en[c]) begin
            src_en[c] <= pwdata[SRC_W-1:0];
          end
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////
  // apb slave: no wait states, ready raised in the first access cycle
  wire logic hit_blk = (idx == ENABLE_IDX);
  wire logic hit_sum = (idx == SUMMARY_IDX);
  wire logic mapped = hit_blk || hit_sum || (|hit_st) || (|hit_en) || (|hit_fs);
  wire logic bad_wr = pwrite && (hit_sum || (|hit_st)); // [RULE1]
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_sum) rd_mux[NUM_CH-1:0] = summary; // [RULE1]
    if (hit_blk) rd_mux[NUM_CH-1:0] = blk_en;
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit_st[i]) rd_mux[SRC_W-1:0] = src_flag[i]; // [RULE6]
      if (hit_en[i]) rd_mux[SRC_W-1:0] = src_en[i];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_en <= ENABLE_RST;
      summary <= SUMMARY_RST; // [RULE1]
      chan_irq <= SUMMARY_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      summary <= next_summary;
      chan_irq <= next_summary;
      if (wr_acc && hit_blk) begin
        blk_en <= pwdata[NUM_CH-1:0]; // [RULE7]
      end
      pready <= setup;
      pslverr <= setup && (!mapped || bad_wr);
      prdata <= setup && !pwrite ? rd_mux : 32'h0000_0000;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_sum_zero_en: assert property (@(posedge pclk) disable iff (!presetn)
    (blk_en == 3'h0) |=> (summary == 3'h0)) // [RULE7]
    else $error("summary set with block enable off");
  a_sum_holds: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(summary[0]) && $past(blk_en[0]) && $past(src_en[0]) == $past(src_en[0], 2))
      |-> $past(rd_acc && hit_st[0])) // [RULE5]
    else $error("summary bit 0 fell without source status read");
  a_sum_or: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2] [RULE8]
    summary[2] == ($past(blk_en[2]) && |(src_flag[2] & $past(src_en[2]))))
    else $error("summary bit 2 not OR of enabled flags");
  a_sum_ch1: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_fs[1] && pwdata[0] && src_en[1][0] && blk_en[1]) |=> summary[1]) // [RULE3]
    else $error("channel 1 event did not set summary");
  a_sum_ch0: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_fs[0] && pwdata[1] && src_en[0][1] && blk_en[0]) |=> summary[0] ##1 summary[0]) // [RULE4]
    else $error("channel 0 event did not set summary");
  a_sum_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_sum) |-> (prdata[31:NUM_CH] == '0 && prdata[NUM_CH-1:0] == $past(summary))) // [RULE1]
    else $error("summary read data wrong");
  a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit_st[2] && !(wr_acc)) |=> src_flag[2] == 8'h00) // [RULE6]
    else $error("source status not cleared by read");
  a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready) // [RULE1]
    else $error("ready not raised in access cycle");
  ////////////////////////////////////////////////////////////////
  // bus timing, read data, error response and channel irq copy
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    pready |-> $past(psel && !penable))
    else $error("ready without preceding setup");

  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    pslverr |-> pready)
    else $error("error flagged outside access cycle");

  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data not zero outside access");

  a_sum_wr_err: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (setup && pwrite && hit_sum) |=> pslverr)
    else $error("write to summary not refused");

  a_st_wr_err: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (setup && pwrite && (|hit_st)) |=> pslverr)
    else $error("write to source status not refused");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (setup && !mapped) |=> pslverr)
    else $error("unmapped access not refused");

  a_good_noerr: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (setup && mapped && !bad_wr) |=> !pslverr)
    else $error("legal access refused");

  a_sum_upper: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (setup && !pwrite && hit_sum) |=> (prdata[31:NUM_CH] == '0))
    else $error("summary unused bits not zero");

  a_fs_rd_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (setup && !pwrite && (|hit_fs)) |=> (prdata == 32'h0000_0000))
    else $error("flag-set register read not zero");

  a_rdata_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (setup && pwrite) |=> (prdata == 32'h0000_0000))
    else $error("read data not zero on write");

  a_irq_copy: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    chan_irq == summary)
    else $error("channel irq differs from summary");

  ////////////////////////////////////////////////////////////////
  // block enable register
  a_blk_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    (wr_acc && hit_blk) |=> (blk_en == $past(pwdata[NUM_CH-1:0])))
    else $error("block enable write lost");

  a_blk_stable: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    !(wr_acc && hit_blk) |=> $stable(blk_en))
    else $error("block enable changed without write");

  a_blk_rd_data: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    (setup && !pwrite && hit_blk) |=> (prdata[NUM_CH-1:0] == $past(blk_en)))
    else $error("block enable read data wrong");

  ////////////////////////////////////////////////////////////////
  // per-channel source flags and enables
  a_flag_clr_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (rd_acc && hit_st[0]) |=> (src_flag[0] == SRC_RST))
    else $error("channel 0 status not cleared by read");

  a_flag_clr_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (rd_acc && hit_st[1]) |=> (src_flag[1] == SRC_RST))
    else $error("channel 1 status not cleared by read");

  a_flag_set_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (wr_acc && hit_fs[0]) |=> (src_flag[0] == ($past(src_flag[0]) | $past(pwdata[SRC_W-1:0]))))
    else $error("channel 0 event not recorded");

  a_flag_set_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (wr_acc && hit_fs[1]) |=> (src_flag[1] == ($past(src_flag[1]) | $past(pwdata[SRC_W-1:0]))))
    else $error("channel 1 event not recorded");

  a_flag_set_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (wr_acc && hit_fs[2]) |=> (src_flag[2] == ($past(src_flag[2]) | $past(pwdata[SRC_W-1:0]))))
    else $error("channel 2 event not recorded");

  a_flag_hold_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    !(acc && (hit_st[0] || hit_fs[0])) |=> $stable(src_flag[0]))
    else $error("channel 0 flags changed without access");

  a_flag_hold_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    !(acc && (hit_st[1] || hit_fs[1])) |=> $stable(src_flag[1]))
    else $error("channel 1 flags changed without access");

  a_flag_hold_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    !(acc && (hit_st[2] || hit_fs[2])) |=> $stable(src_flag[2]))
    else $error("channel 2 flags changed without access");

  a_en_write_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (wr_acc && hit_en[0]) |=> (src_en[0] == $past(pwdata[SRC_W-1:0])))
    else $error("channel 0 source enable write lost");

  a_en_write_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (wr_acc && hit_en[1]) |=> (src_en[1] == $past(pwdata[SRC_W-1:0])))
    else $error("channel 1 source enable write lost");

  a_en_write_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (wr_acc && hit_en[2]) |=> (src_en[2] == $past(pwdata[SRC_W-1:0])))
    else $error("channel 2 source enable write lost");

  a_en_hold_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    !(wr_acc && hit_en[0]) |=> $stable(src_en[0]))
    else $error("channel 0 source enable changed without write");

  a_en_hold_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    !(wr_acc && hit_en[1]) |=> $stable(src_en[1]))
    else $error("channel 1 source enable changed without write");

  a_en_hold_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    !(wr_acc && hit_en[2]) |=> $stable(src_en[2]))
    else $error("channel 2 source enable changed without write");

  a_st_rd_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (setup && !pwrite && hit_st[0]) |=> (prdata[SRC_W-1:0] == $past(src_flag[0])))
    else $error("channel 0 status read data wrong");

  a_st_rd_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (setup && !pwrite && hit_st[1]) |=> (prdata[SRC_W-1:0] == $past(src_flag[1])))
    else $error("channel 1 status read data wrong");

  a_st_rd_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (setup && !pwrite && hit_st[2]) |=> (prdata[SRC_W-1:0] == $past(src_flag[2])))
    else $error("channel 2 status read data wrong");

  ////////////////////////////////////////////////////////////////
  // per-channel summary bits
  a_sum_or_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4] [RULE8]
    summary[0] == ($past(blk_en[0]) && |(src_flag[0] & $past(src_en[0]))))
    else $error("summary bit 0 not OR of enabled flags");

  a_sum_or_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3] [RULE8]
    summary[1] == ($past(blk_en[1]) && |(src_flag[1] & $past(src_en[1]))))
    else $error("summary bit 1 not OR of enabled flags");

  a_sum_gate_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    !blk_en[0] |=> !summary[0])
    else $error("summary bit 0 set with channel disabled");

  a_sum_gate_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    !blk_en[1] |=> !summary[1])
    else $error("summary bit 1 set with channel disabled");

  a_sum_gate_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    !blk_en[2] |=> !summary[2])
    else $error("summary bit 2 set with channel disabled");

  a_sum_nosrc_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (src_en[0] == SRC_RST) |=> !summary[0])
    else $error("summary bit 0 set with no source enabled");

  a_sum_nosrc_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (src_en[1] == SRC_RST) |=> !summary[1])
    else $error("summary bit 1 set with no source enabled");

  a_sum_nosrc_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (src_en[2] == SRC_RST) |=> !summary[2])
    else $error("summary bit 2 set with no source enabled");

  a_sum_keep_ch0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (summary[0] && blk_en[0] && $stable(src_en[0]) && !(rd_acc && hit_st[0]))
      |=> summary[0])
    else $error("summary bit 0 dropped without status read");

  a_sum_keep_ch1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (summary[1] && blk_en[1] && $stable(src_en[1]) && !(rd_acc && hit_st[1]))
      |=> summary[1])
    else $error("summary bit 1 dropped without status read");

  a_sum_keep_ch2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (summary[2] && blk_en[2] && $stable(src_en[2]) && !(rd_acc && hit_st[2]))
      |=> summary[2])
    else $error("summary bit 2 dropped without status read");
endmodule
`default_nettype wire
